// ### sim/tmr16_core_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tmr16_core_tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:1] tick_enable;
  logic event_pin, comparator_out, event_irq_ack, wrap_irq_ack;
  logic event_irq, wrap_irq, at_top, at_bottom, count_down;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 pclk = ~pclk;
  tmr16_core tmr16_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick_enable(tick_enable), .event_pin(event_pin),
    .comparator_out(comparator_out), .event_irq_ack(event_irq_ack),
    .wrap_irq_ack(wrap_irq_ack), .event_irq(event_irq), .wrap_irq(wrap_irq),
    .at_top(at_top), .at_bottom(at_bottom), .count_down(count_down));
  tmr16_cpu_model tmr16_cpu_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  // Wait n edges, then look between edges
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wt
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] q;
    logic e;
    logic [15:0] v;
    presetn = 1'b0;
    tick_enable = 7'h00;
    event_pin = 1'b0;
    comparator_out = 1'b0;
    event_irq_ack = 1'b0;
    wrap_irq_ack = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Every word reads zero after reset, and a hole is refused
    for (int a = 0; a <= 8'h30; a += 4)
    begin
      tmr16_cpu_model_i.rd8(8'(a), q, e);
      `CHK(q, 8'h00);
    end
    tmr16_cpu_model_i.rd8(8'h34, q, e);
    `CHK(e, 1'b1);
    // Stopped counter ignores ticks but takes writes
    tick_enable <= 7'h7f;
    tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_CNT_LO, 16'h01ff);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_CNT_LO, v);
    `CHK(v, 16'h01ff);
    tick_enable <= 7'h00;
    // One high byte serves two match registers
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_MA_HI, 8'h5a);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_MA_LO, 8'h11);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_MB_LO, 8'h22);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_MB_LO, v);
    `CHK(v, 16'h5a22);
    tmr16_cpu_model_i.rd8(tmr16_pkg::ADDR_CNT_LO, q, e);
    tmr16_cpu_model_i.rd8(tmr16_pkg::ADDR_MA_HI, q, e);
    `CHK(q, 8'h5a);
    tmr16_cpu_model_i.rd8(tmr16_pkg::ADDR_CNT_HI, q, e);
    `CHK(q, 8'h01);
    // Stamp refuses writes until it is the top
    tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_STP_LO, 16'h0abc);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_STP_LO, v);
    `CHK(v, 16'h0000);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_B, 8'h18);
    tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_STP_LO, 16'h0abc);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_STP_LO, v);
    `CHK(v, 16'h0abc);
    tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_CNT_LO, 16'h0abc);
    wt(0);
    `CHK(at_top, 1'b1);
    // Fixed tops of modes one to three
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_B, 8'h00);
    for (int m = 1; m <= 3; m++)
    begin
      tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_A, 8'(m));
      tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_CNT_LO, (16'h0100 << (m - 1)) - 16'h0001);
      wt(0);
      `CHK(at_top, 1'b1);
    end
    // Dual slope turns down at its top
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_B, 8'h01);
    @(posedge pclk) tick_enable <= 7'h01;
    @(posedge pclk) tick_enable <= 7'h00;
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_CNT_LO, v);
    `CHK({count_down, v}, 17'h103fe);
    // Counting on the selected tick only, through the wrap
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_A, 8'h00);
    tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_CNT_LO, 16'hfffd);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_IRQ_EN, 8'h03);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_B, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk) tick_enable <= 7'h01;
      @(posedge pclk) tick_enable <= 7'h7e;
    end
    @(posedge pclk) tick_enable <= 7'h00;
    wt(0);
    `CHK({at_bottom, wrap_irq}, 2'b11);
    @(posedge pclk) wrap_irq_ack <= 1'b1;
    @(posedge pclk) wrap_irq_ack <= 1'b0;
    wt(0);
    `CHK(wrap_irq, 1'b0);
    // A write wins over a tick on the same edge
    fork
      tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_CNT_LO, 16'h0100);
      begin
        repeat (5) @(posedge pclk);
        tick_enable <= 7'h01;
        @(posedge pclk) tick_enable <= 7'h00;
      end
    join
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_B, 8'h40);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_CNT_LO, v);
    `CHK(v, 16'h0100);
    // Rising pin edge stamps the count and raises the flag
    @(posedge pclk) event_pin <= 1'b1;
    wt(8);
    `CHK(event_irq, 1'b1);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_STP_LO, v);
    `CHK(v, 16'h0100);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_FLAGS, 8'h01);
    wt(0);
    `CHK(event_irq, 1'b1);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_FLAGS, 8'h02);
    wt(0);
    `CHK(event_irq, 1'b0);
    // Falling edge is ignored; the comparator then takes over
    tmr16_cpu_model_i.wr16(tmr16_pkg::ADDR_CNT_LO, 16'h0200);
    @(posedge pclk) event_pin <= 1'b0;
    wt(8);
    `CHK(event_irq, 1'b0);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CMP_CTL, 8'h04);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_FLAGS, 8'h02);
    @(posedge pclk) comparator_out <= 1'b1;
    wt(8);
    tmr16_cpu_model_i.rd16(tmr16_pkg::ADDR_STP_LO, v);
    `CHK(v, 16'h0200);
    @(posedge pclk) event_irq_ack <= 1'b1;
    @(posedge pclk) event_irq_ack <= 1'b0;
    wt(0);
    `CHK(event_irq, 1'b0);
    // Filter swallows a three-cycle glitch, passes a steady level
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_CTRL_B, 8'hc0);
    @(posedge pclk) comparator_out <= 1'b0;
    wt(10);
    tmr16_cpu_model_i.wr8(tmr16_pkg::ADDR_FLAGS, 8'h02);
    @(posedge pclk) comparator_out <= 1'b1;
    repeat (3) @(posedge pclk);
    comparator_out <= 1'b0;
    wt(12);
    `CHK(event_irq, 1'b0);
    @(posedge pclk) comparator_out <= 1'b1;
    wt(12);
    `CHK(event_irq, 1'b1);
    complete_run();
  end
endmodule : tmr16_core_tb

// ### sim/tmr16_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Byte-wide processor on the register bus
// ----------------------------------------------------------------
module tmr16_cpu_model (
  // Clock
  input wire logic pclk,
  // Requests
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answers
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer; on release the write data shows the inverse of its last value
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask : xfer
  // Byte accesses
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr8
  task automatic rd8(input logic [7:0] a, output logic [7:0] q, output logic e);
    xfer(1'b0, a, 8'h00, q, e);
  endtask : rd8
  // Word pairs sit four bytes apart; no other access slips between the halves
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr8(lo + 8'h04, v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    logic e;
    rd8(lo, v[7:0], e);
    rd8(lo + 8'h04, v[15:8], e);
  endtask : rd16
endmodule : tmr16_cpu_model

// ### sim/tmr16_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module tmr16_monitor (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer side
  input wire logic [7:1] tick_enable,
  input wire logic event_pin,
  input wire logic comparator_out,
  input wire logic event_irq_ack,
  input wire logic wrap_irq_ack,
  input wire logic event_irq,
  input wire logic wrap_irq,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic count_down
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;             // Transfer taken this edge
  logic mapped;          // Address hits a word
  logic hi_wr;           // High byte write
  logic lo_rd;           // Low read that reloads the latch
  logic [7:0] latch_q;   // Shadow of the shared latch
  logic latch_ok_q;      // Shadow value is known
  logic [15:0] ma_q;     // Shadow of match A
  logic ma_ok_q;         // Match A shadow is known
  assign acc = psel && penable && pready;
  assign mapped = (paddr <= tmr16_pkg::ADDR_CMP_CTL) && (paddr[1:0] == 2'b00);
  assign hi_wr = acc && pwrite && (paddr inside {tmr16_pkg::ADDR_CNT_HI,
    tmr16_pkg::ADDR_MA_HI, tmr16_pkg::ADDR_MB_HI, tmr16_pkg::ADDR_STP_HI});
  assign lo_rd = acc && !pwrite && (paddr inside {tmr16_pkg::ADDR_CNT_LO,
    tmr16_pkg::ADDR_STP_LO});
  // ----------------------------------------------------------------
  // Shadow latch and match A
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_q <= 8'h00;
      latch_ok_q <= 1'b1;
    end
    else if (hi_wr)
    begin
      latch_q <= pwdata[7:0];
      latch_ok_q <= 1'b1;
    end
    else if (lo_rd)
    begin
      latch_ok_q <= 1'b0;
    end
  end
  // Match A loads latch and low byte together
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ma_q <= 16'h0000;
      ma_ok_q <= 1'b1;
    end
    else if (acc && pwrite && paddr == tmr16_pkg::ADDR_MA_LO)
    begin
      ma_q <= {latch_q, pwdata[7:0]};
      ma_ok_q <= latch_ok_q;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_flag_wr;
    acc && pwrite && paddr == tmr16_pkg::ADDR_FLAGS;
  endsequence
  sequence s_rd_at(logic [7:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  a_flag_one_clr: assert property (s_flag_wr ##0 pwdata[1] |=> !event_irq)
    else $error("event flag kept after write of one");
  a_flag_zero_keep: assert property (s_flag_wr ##0 (!pwdata[1] && event_irq && !event_irq_ack)
    |=> event_irq)
    else $error("event flag lost on write of zero");
  a_event_ack_clr: assert property (event_irq && event_irq_ack |=> !event_irq)
    else $error("event flag kept after service");
  a_wrap_ack_clr: assert property (wrap_irq && wrap_irq_ack |=> !wrap_irq)
    else $error("wrap flag kept after service");
  a_latch_read: assert property ((s_rd_at(tmr16_pkg::ADDR_CNT_HI) or
    s_rd_at(tmr16_pkg::ADDR_STP_HI)) ##0 latch_ok_q |-> prdata[7:0] == latch_q)
    else $error("high read not served by latch");
  a_match_direct: assert property (s_rd_at(tmr16_pkg::ADDR_MA_HI) ##0 ma_ok_q
    |-> prdata[7:0] == ma_q[15:8])
    else $error("match high read wrong");
  a_match_low: assert property (s_rd_at(tmr16_pkg::ADDR_MA_LO) ##0 ma_ok_q
    |-> prdata[7:0] == ma_q[7:0])
    else $error("match low read wrong");
  a_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("slave error does not follow the map");
  a_reset_state: assert property ($rose(presetn) |-> at_bottom && !event_irq && !wrap_irq)
    else $error("state not cleared by reset");
endmodule : tmr16_monitor

bind tmr16_core tmr16_monitor tmr16_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tick_enable(tick_enable), .event_pin(event_pin),
  .comparator_out(comparator_out), .event_irq_ack(event_irq_ack),
  .wrap_irq_ack(wrap_irq_ack), .event_irq(event_irq), .wrap_irq(wrap_irq),
  .at_top(at_top), .at_bottom(at_bottom), .count_down(count_down));

// ### verilog/tmr16_core.sv
`timescale 1ns/1ps
module tmr16_core (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer tick and capture sources
  input wire logic [7:1] tick_enable,
  input wire logic event_pin,
  input wire logic comparator_out,
  // Interrupt service acknowledges
  input wire logic event_irq_ack,
  input wire logic wrap_irq_ack,
  // Status outputs
  output logic event_irq,
  output logic wrap_irq,
  output logic at_top,
  output logic at_bottom,
  output logic count_down
);

  // Filter depth
  localparam int FILT_W = tmr16_pkg::FILT_LEN;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] hi_latch_q;     // Shared high-byte latch
  logic [15:0] count_value_q; // Counter
  logic [15:0] match_a_q;     // Match A
  logic [15:0] match_b_q;     // Match B
  logic [15:0] event_stamp_q; // Capture register
  logic [7:0] timer_ctrl_a_q; // Control A
  logic [7:0] timer_ctrl_b_q; // Control B
  logic [1:0] irq_en_q;       // Wrap and event enables
  logic cmp_sel_q;            // comparator_event_sel
  logic wrap_flag_q;          // Overflow flag
  logic event_flag_q;         // Capture flag
  logic dir_down_q;           // Count direction
  logic [FILT_W-1:0] filt_q;  // Filter sample history
  logic filt_out_q;           // Filtered level
  logic edge_prev_q;          // Previous level for edge detect
  logic [31:0] prdata_q;      // Read data

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc;       // Access phase, answered at once
  logic wr;        // Write strobe
  logic rd;        // Read setup: data and latch sampled together
  logic mapped;    // Address is in the map
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  // Zero wait states: every access answered at once
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // Mapped address check
  always_comb
  begin
    unique case (paddr)
      tmr16_pkg::ADDR_CTRL_A, tmr16_pkg::ADDR_CTRL_B, tmr16_pkg::ADDR_CNT_LO,
      tmr16_pkg::ADDR_CNT_HI, tmr16_pkg::ADDR_MA_LO, tmr16_pkg::ADDR_MA_HI,
      tmr16_pkg::ADDR_MB_LO, tmr16_pkg::ADDR_MB_HI, tmr16_pkg::ADDR_STP_LO,
      tmr16_pkg::ADDR_STP_HI, tmr16_pkg::ADDR_FLAGS, tmr16_pkg::ADDR_IRQ_EN,
      tmr16_pkg::ADDR_CMP_CTL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic [3:0] wave_mode_sel;   // Split field
  logic [2:0] tick_source_sel; // Clock select
  logic tick;                  // Timer tick this cycle
  logic [15:0] top_val;        // Current top
  logic dual_slope;            // Phase-correct modes
  logic clear_at_top;          // Clear-on-top modes
  logic stamp_is_top;          // Capture register used as top
  // Low mode half in control A, high half in control B
  assign wave_mode_sel = {timer_ctrl_b_q[tmr16_pkg::CB_WGM_HI +: 2],
                          timer_ctrl_a_q[tmr16_pkg::CA_WGM_LO +: 2]};
  // Source zero selects nothing, so the counter holds
  assign tick_source_sel = timer_ctrl_b_q[tmr16_pkg::CB_CS_LO +: 3];
  assign tick = (tick_source_sel != 3'h0) & tick_enable[tick_source_sel];

  // Top value, counting style per mode
  always_comb
  begin
    top_val = tmr16_pkg::TOP_MAX;
    dual_slope = 1'b0;
    clear_at_top = 1'b0;
    stamp_is_top = 1'b0;
    unique case (wave_mode_sel)
      4'h0: top_val = tmr16_pkg::TOP_MAX;
      4'h1: begin top_val = tmr16_pkg::TOP_8BIT; dual_slope = 1'b1; end
      4'h2: begin top_val = tmr16_pkg::TOP_9BIT; dual_slope = 1'b1; end
      4'h3: begin top_val = tmr16_pkg::TOP_10BIT; dual_slope = 1'b1; end
      4'h4: begin top_val = match_a_q; clear_at_top = 1'b1; end
      4'h5: begin top_val = tmr16_pkg::TOP_8BIT; clear_at_top = 1'b1; end
      4'h6: begin top_val = tmr16_pkg::TOP_9BIT; clear_at_top = 1'b1; end
      4'h7: begin top_val = tmr16_pkg::TOP_10BIT; clear_at_top = 1'b1; end
      4'h8, 4'ha:
      begin
        top_val = event_stamp_q;
        dual_slope = 1'b1;
        stamp_is_top = 1'b1;
      end
      4'h9, 4'hb: begin top_val = match_a_q; dual_slope = 1'b1; end
      4'hc, 4'he:
      begin
        top_val = event_stamp_q;
        clear_at_top = 1'b1;
        stamp_is_top = 1'b1;
      end
      4'hd: top_val = tmr16_pkg::TOP_MAX;
      4'hf: begin top_val = match_a_q; clear_at_top = 1'b1; end
    endcase
  end

  // Top and bottom compare the live count
  assign at_top = (count_value_q == top_val);
  assign at_bottom = (count_value_q == tmr16_pkg::CNT_ZERO);
  assign count_down = dir_down_q;

  // Wrap point: top in single-slope, bottom in dual-slope
  logic wrap_evt;
  assign wrap_evt = tick & (dual_slope ? at_bottom & dir_down_q :
                    (clear_at_top ? at_top : (count_value_q == tmr16_pkg::TOP_MAX)));

  // Write and read strobes per address
  logic wr_cnt_lo, wr_stp_lo, rd_cnt_lo, rd_stp_lo;
  assign wr_cnt_lo = wr & (paddr == tmr16_pkg::ADDR_CNT_LO);
  assign wr_stp_lo = wr & (paddr == tmr16_pkg::ADDR_STP_LO) & stamp_is_top;
  assign rd_cnt_lo = rd & (paddr == tmr16_pkg::ADDR_CNT_LO);
  assign rd_stp_lo = rd & (paddr == tmr16_pkg::ADDR_STP_LO);

  // ----------------------------------------------------------------
  // Shared high-byte latch
  // ----------------------------------------------------------------
  // Loaded by any high-byte write, or by a low-byte read of count/stamp
  // A low read loads it in its setup cycle, on the edge that
  // also samples the low byte, so both halves match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_latch_q <= 8'h00;
    else if (wr & ((paddr == tmr16_pkg::ADDR_CNT_HI) | (paddr == tmr16_pkg::ADDR_MA_HI) |
             (paddr == tmr16_pkg::ADDR_MB_HI) | (paddr == tmr16_pkg::ADDR_STP_HI)))
      hi_latch_q <= pwdata[7:0];
    else if (rd_cnt_lo)
      hi_latch_q <= count_value_q[15:8];
    else if (rd_stp_lo)
      hi_latch_q <= event_stamp_q[15:8];
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A software write beats a tick on the same edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value_q <= 16'h0000;
    else if (wr_cnt_lo)
      count_value_q <= {hi_latch_q, pwdata[7:0]};
    else if (tick)
    begin
      if (dual_slope)
        count_value_q <= (dir_down_q | at_top) ? count_value_q - 16'h0001 :
                         count_value_q + 16'h0001;
      else if (clear_at_top & at_top)
        count_value_q <= tmr16_pkg::CNT_ZERO;
      else
        count_value_q <= count_value_q + 16'h0001;
    end
  end

  // Direction: turns down at top, up at bottom in dual-slope modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_down_q <= 1'b0;
    else if (!dual_slope)
      dir_down_q <= 1'b0;
    else if (tick & at_top)
      dir_down_q <= 1'b1;
    else if (tick & at_bottom)
      dir_down_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Match registers and control
  // ----------------------------------------------------------------
  // Control, enables and match words load from the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_a_q <= 16'h0000;
      match_b_q <= 16'h0000;
      timer_ctrl_a_q <= 8'h00;
      timer_ctrl_b_q <= 8'h00;
      irq_en_q <= 2'h0;
      cmp_sel_q <= 1'b0;
    end
    else if (wr)
    begin
      unique case (paddr)
        tmr16_pkg::ADDR_MA_LO: match_a_q <= {hi_latch_q, pwdata[7:0]};
        tmr16_pkg::ADDR_MB_LO: match_b_q <= {hi_latch_q, pwdata[7:0]};
        tmr16_pkg::ADDR_CTRL_A: timer_ctrl_a_q <= pwdata[7:0];
        tmr16_pkg::ADDR_CTRL_B: timer_ctrl_b_q <= pwdata[7:0];
        tmr16_pkg::ADDR_IRQ_EN: irq_en_q <= pwdata[1:0];
        tmr16_pkg::ADDR_CMP_CTL: cmp_sel_q <= pwdata[tmr16_pkg::CC_SEL];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Capture input: source select, filter, edge detect
  // ----------------------------------------------------------------
  logic src_lvl;
  logic cap_lvl;
  logic cap_trig;
  assign src_lvl = cmp_sel_q ? comparator_out : event_pin;

  // Filter: output follows only after four equal samples
  // History shifts every cycle; output moves on a full run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_q <= '0;
      filt_out_q <= 1'b0;
    end
    else
    begin
      filt_q <= {filt_q[FILT_W-2:0], src_lvl};
      if (&filt_q)
        filt_out_q <= 1'b1;
      else if (~|filt_q)
        filt_out_q <= 1'b0;
    end
  end

  assign cap_lvl = timer_ctrl_b_q[tmr16_pkg::CB_FILT] ? filt_out_q : src_lvl;

  // Previous level for edge detection
  // Reset level matches idle pins, so no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_prev_q <= 1'b0;
    else
      edge_prev_q <= cap_lvl;
  end

  // Edge matches the edge setting; off while stamp defines top
  assign cap_trig = ~stamp_is_top & (cap_lvl != edge_prev_q) &
                    (cap_lvl == timer_ctrl_b_q[tmr16_pkg::CB_EDGE]);

  // Capture register
  // Software load only while it is top; capture off then
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_stamp_q <= 16'h0000;
    else if (wr_stp_lo)
      event_stamp_q <= {hi_latch_q, pwdata[7:0]};
    else if (cap_trig)
      event_stamp_q <= count_value_q;
  end

  // ----------------------------------------------------------------
  // Flags: set wins over clear
  // ----------------------------------------------------------------
  logic wr_flags;
  assign wr_flags = wr & (paddr == tmr16_pkg::ADDR_FLAGS);

  // Capture sets; a one or a service clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_flag_q <= 1'b0;
    else if (cap_trig)
      event_flag_q <= 1'b1;
    else if ((wr_flags & pwdata[tmr16_pkg::FL_EVENT]) | event_irq_ack)
      event_flag_q <= 1'b0;
  end

  // Wrap point sets; a one or a service clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wrap_flag_q <= 1'b0;
    else if (wrap_evt)
      wrap_flag_q <= 1'b1;
    else if ((wr_flags & pwdata[tmr16_pkg::FL_WRAP]) | wrap_irq_ack)
      wrap_flag_q <= 1'b0;
  end

  // Requests are flag and enable
  // Enables share the flag bit positions
  assign event_irq = event_flag_q & irq_en_q[tmr16_pkg::FL_EVENT];
  assign wrap_irq = wrap_flag_q & irq_en_q[tmr16_pkg::FL_WRAP];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Sampled in the setup cycle, held through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (paddr)
        tmr16_pkg::ADDR_CTRL_A: prdata_q <= {24'h0, timer_ctrl_a_q};
        tmr16_pkg::ADDR_CTRL_B: prdata_q <= {24'h0, timer_ctrl_b_q};
        tmr16_pkg::ADDR_CNT_LO: prdata_q <= {24'h0, count_value_q[7:0]};
        tmr16_pkg::ADDR_CNT_HI: prdata_q <= {24'h0, hi_latch_q};
        tmr16_pkg::ADDR_MA_LO: prdata_q <= {24'h0, match_a_q[7:0]};
        tmr16_pkg::ADDR_MA_HI: prdata_q <= {24'h0, match_a_q[15:8]};
        tmr16_pkg::ADDR_MB_LO: prdata_q <= {24'h0, match_b_q[7:0]};
        tmr16_pkg::ADDR_MB_HI: prdata_q <= {24'h0, match_b_q[15:8]};
        tmr16_pkg::ADDR_STP_LO: prdata_q <= {24'h0, event_stamp_q[7:0]};
        tmr16_pkg::ADDR_STP_HI: prdata_q <= {24'h0, hi_latch_q};
        tmr16_pkg::ADDR_FLAGS: prdata_q <= {30'h0, event_flag_q, wrap_flag_q};
        tmr16_pkg::ADDR_IRQ_EN: prdata_q <= {30'h0, irq_en_q};
        tmr16_pkg::ADDR_CMP_CTL: prdata_q <= {29'h0, cmp_sel_q, 2'h0};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

endmodule : tmr16_core

// ### verilog/tmr16_pkg.sv
package tmr16_pkg;

  // ----------------------------------------------------------------
  // Register word offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;   // timer_ctrl_a
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;   // timer_ctrl_b
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;   // count_value_lo
  localparam logic [7:0] ADDR_CNT_HI = 8'h0c;   // count_value_hi
  localparam logic [7:0] ADDR_MA_LO = 8'h10;    // match A low
  localparam logic [7:0] ADDR_MA_HI = 8'h14;    // match A high
  localparam logic [7:0] ADDR_MB_LO = 8'h18;    // match B low
  localparam logic [7:0] ADDR_MB_HI = 8'h1c;    // match B high
  localparam logic [7:0] ADDR_STP_LO = 8'h20;   // event_stamp_lo
  localparam logic [7:0] ADDR_STP_HI = 8'h24;   // event_stamp_hi
  localparam logic [7:0] ADDR_FLAGS = 8'h28;    // flags, write one to clear
  localparam logic [7:0] ADDR_IRQ_EN = 8'h2c;   // interrupt enables
  localparam logic [7:0] ADDR_CMP_CTL = 8'h30;  // comparator control

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_WGM_LO = 0;    // timer_ctrl_a: wave_mode_sel[1:0] at 1:0
  localparam int CB_CS_LO = 0;     // timer_ctrl_b: tick_source_sel at 2:0
  localparam int CB_WGM_HI = 3;    // timer_ctrl_b: wave_mode_sel[3:2] at 4:3
  localparam int CB_EDGE = 6;      // timer_ctrl_b: capture edge, 1 = rising
  localparam int CB_FILT = 7;      // timer_ctrl_b: event_filter_en
  localparam int FL_WRAP = 0;      // wrap_flag
  localparam int FL_EVENT = 1;     // event_flag
  localparam int CC_SEL = 2;       // comparator_event_sel

  // ----------------------------------------------------------------
  // Fixed tops and filter length
  // ----------------------------------------------------------------
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam int FILT_LEN = 4;

endpackage : tmr16_pkg
